// ### hw/core_sfr.sv
/*
  Core special registers: stack top, indirect pointer, status word,
  main and aux operands, with a small arithmetic unit that sets flags.
  Assumes a same-clock Avalon-MM master with waitrequest.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Stack pointer increments before each push
// - Stack pointer resets to 0x07, fully writable
// - Pointer is high byte then low byte
// - Pointer addresses external data and code
// - Carry set on carry or borrow
// - Nibble carry set on nibble carry/borrow
// - Bank select picks working register bank
// - Overflow on signed wrap, MUL>255, DIV zero
// - Overflow cleared by arithmetic otherwise
// - Parity bit read-only, odd ones of operand
// - User flags change only by software
// - Main operand eight bits, resets zero
// - Aux operand eight bits, resets zero
// - Registers decoded at fixed page-free addresses
module core_sfr
  import core_sfr_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Core views
  output logic      [15:0] indirect_pointer,
  output logic      [4:0]  bank_base_addr
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic odd_ones(input logic [7:0] v);
    odd_ones = ^v;
  endfunction : odd_ones

  function automatic logic [7:0] set_bit(input logic [7:0] v,
      input logic [2:0] sel, input logic val);
    logic [7:0] r;
    r = v;
    r[sel] = val;
    set_bit = r;
  endfunction : set_bit

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  stack_top_reg, stack_top_next;
  logic [7:0]  ptr_low_reg, ptr_low_next;
  logic [7:0]  ptr_high_reg, ptr_high_next;
  logic [7:0]  status_reg, status_next;
  logic [7:0]  main_reg, main_next;
  logic [7:0]  aux_reg, aux_next;
  logic [7:0]  push_data_reg, push_data_next;
  bus_state_t  bus_reg, bus_next;
  logic        wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [15:0] ptr_out_reg, ptr_out_next;
  logic [4:0]  bank_reg, bank_next;
  avmm_req_t   req;
  logic [7:0]  idx;
  logic        wr_go;
  logic        rd_go;

  assign req = '{read: avs_read, write: avs_write,
                 address: avs_address, writedata: avs_writedata};
  assign idx = req.address[9:2];
  assign wr_go = (bus_reg == BUS_IDLE) && req.write;
  assign rd_go = (bus_reg == BUS_IDLE) && req.read;

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0]  sum;
    logic [4:0]  nib;
    logic [15:0] prod;
    logic [7:0]  wd;
    logic [7:0]  flags;
    logic        cin;
    alu_op_t     op;
    bit_tgt_t    tgt;
    logic [2:0]  bsel;
    logic        bval;
    sum = 9'h000;
    nib = 5'h00;
    prod = 16'h0000;
    wd = req.writedata[7:0];
    flags = status_reg;
    cin = status_reg[POS_CARRY];
    op = alu_op_t'(wd[2:0]);
    tgt = bit_tgt_t'(wd[BITOP_TGT_LO +: 3]);
    bsel = wd[BITOP_SEL_LO +: 3];
    bval = wd[BITOP_VAL];
    stack_top_next = stack_top_reg;
    ptr_low_next = ptr_low_reg;
    ptr_high_next = ptr_high_reg;
    status_next = status_reg;
    main_next = main_reg;
    aux_next = aux_reg;
    push_data_next = push_data_reg;
    if (wr_go) begin
      if (idx == IDX_STACK_TOP) begin
        stack_top_next = wd;
      end else if (idx == IDX_PTR_LOW) begin
        ptr_low_next = wd;
      end else if (idx == IDX_PTR_HIGH) begin
        ptr_high_next = wd;
      end else if (idx == IDX_PTR_WORD) begin
        ptr_low_next = req.writedata[7:0];
        ptr_high_next = req.writedata[15:8];
      end else if (idx == IDX_STATUS) begin
        status_next = wd & STATUS_SW_MASK;
      end else if (idx == IDX_MAIN_OP) begin
        main_next = wd;
      end else if (idx == IDX_AUX_OP) begin
        aux_next = wd;
      end else if (idx == IDX_PUSH) begin
        stack_top_next = stack_top_reg + 8'h01;
        push_data_next = wd;
      end else if (idx == IDX_BIT_OP) begin
        case (tgt)
          TGT_STACK:    stack_top_next = set_bit(stack_top_reg, bsel, bval);
          TGT_PTR_LOW:  ptr_low_next = set_bit(ptr_low_reg, bsel, bval);
          TGT_PTR_HIGH: ptr_high_next = set_bit(ptr_high_reg, bsel, bval);
          TGT_STATUS:   status_next = set_bit(status_reg, bsel, bval)
                                      & STATUS_SW_MASK;
          TGT_MAIN:     main_next = set_bit(main_reg, bsel, bval);
          TGT_AUX:      aux_next = set_bit(aux_reg, bsel, bval);
          default:      status_next = status_reg;
        endcase
      end else if (idx == IDX_ALU_CMD) begin
        case (op)
          ALU_ADD, ALU_ADDC: begin
            sum = {1'b0, main_reg} + {1'b0, aux_reg}
                  + {8'h00, (op == ALU_ADDC) & cin};
            nib = {1'b0, main_reg[3:0]} + {1'b0, aux_reg[3:0]}
                  + {4'h0, (op == ALU_ADDC) & cin};
            main_next = sum[7:0];
            flags[POS_CARRY] = sum[8];
            flags[POS_NIBBLE] = nib[4];
            flags[POS_SIGN_WRAP] = (main_reg[7] == aux_reg[7])
                                   && (sum[7] != main_reg[7]);
          end
          ALU_SUBB: begin
            sum = {1'b0, main_reg} - {1'b0, aux_reg} - {8'h00, cin};
            nib = {1'b0, main_reg[3:0]} - {1'b0, aux_reg[3:0]}
                  - {4'h0, cin};
            main_next = sum[7:0];
            flags[POS_CARRY] = sum[8];
            flags[POS_NIBBLE] = nib[4];
            flags[POS_SIGN_WRAP] = (main_reg[7] != aux_reg[7])
                                   && (sum[7] != main_reg[7]);
          end
          ALU_MUL: begin
            prod = {8'h00, main_reg} * {8'h00, aux_reg};
            main_next = prod[7:0];
            aux_next = prod[15:8];
            flags[POS_CARRY] = 1'b0;
            flags[POS_NIBBLE] = 1'b0;
            flags[POS_SIGN_WRAP] = (prod > {8'h00, MUL_LIMIT});
          end
          ALU_DIV: begin
            flags[POS_CARRY] = 1'b0;
            flags[POS_NIBBLE] = 1'b0;
            flags[POS_SIGN_WRAP] = (aux_reg == 8'h00);
            if (aux_reg != 8'h00) begin
              main_next = main_reg / aux_reg;
              aux_next = main_reg % aux_reg;
            end
          end
          default: flags = status_reg;
        endcase
        status_next = flags;
      end
    end
    status_next[POS_ODD_ONES] = odd_ones(main_next);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stack_top_reg <= RST_STACK_TOP;
      ptr_low_reg <= RST_ZERO;
      ptr_high_reg <= RST_ZERO;
      status_reg <= RST_ZERO;
      main_reg <= RST_ZERO;
      aux_reg <= RST_ZERO;
      push_data_reg <= RST_ZERO;
    end else begin
      stack_top_reg <= stack_top_next;
      ptr_low_reg <= ptr_low_next;
      ptr_high_reg <= ptr_high_next;
      status_reg <= status_next;
      main_reg <= main_next;
      aux_reg <= aux_next;
      push_data_reg <= push_data_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer and outputs
  // ----------------------------------------------------------------
  always_comb begin
    bus_next = BUS_IDLE;
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    if (wr_go || rd_go) begin
      bus_next = BUS_DONE;
      wait_next = 1'b0;
    end
    if (rd_go) begin
      rdata_next = 32'h0000_0000;
      if (idx == IDX_STACK_TOP) begin
        rdata_next[7:0] = stack_top_reg;
      end else if (idx == IDX_PTR_LOW) begin
        rdata_next[7:0] = ptr_low_reg;
      end else if (idx == IDX_PTR_HIGH) begin
        rdata_next[7:0] = ptr_high_reg;
      end else if (idx == IDX_PTR_WORD) begin
        rdata_next[15:0] = {ptr_high_reg, ptr_low_reg};
      end else if (idx == IDX_STATUS) begin
        rdata_next[7:0] = status_reg;
      end else if (idx == IDX_MAIN_OP) begin
        rdata_next[7:0] = main_reg;
      end else if (idx == IDX_AUX_OP) begin
        rdata_next[7:0] = aux_reg;
      end else if (idx == IDX_PUSH) begin
        rdata_next[7:0] = push_data_reg;
      end else if (idx == IDX_BANK_BASE) begin
        rdata_next[4:0] = bank_reg;
      end
    end
    ptr_out_next = {ptr_high_next, ptr_low_next};
    bank_next = {status_next[POS_BANK_HI], status_next[POS_BANK_LO], 3'b000};
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_reg <= BUS_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      ptr_out_reg <= 16'h0000;
      bank_reg <= 5'h00;
    end else begin
      bus_reg <= bus_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      ptr_out_reg <= ptr_out_next;
      bank_reg <= bank_next;
    end
  end

  // ----------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign indirect_pointer = ptr_out_reg;
  assign bank_base_addr = bank_reg;

endmodule : core_sfr
`default_nettype wire

// ### hw/core_sfr_pkg.sv
/*
  Constants and carriers for the core special-register set.
  Assumes an Avalon-MM slave with 32-bit data on one word per register.
*/
package core_sfr_pkg;

  // ----------------------------------------------------------------
  // Register indices (printed offsets); byte address is the index shifted left by two
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_STACK_TOP  = 8'h81;
  localparam logic [7:0]  IDX_PTR_LOW    = 8'h82;
  localparam logic [7:0]  IDX_PTR_HIGH   = 8'h83;
  localparam logic [7:0]  IDX_STATUS     = 8'hD0;
  localparam logic [7:0]  IDX_MAIN_OP    = 8'hE0;
  localparam logic [7:0]  IDX_AUX_OP     = 8'hF0;
  // Own registers: arithmetic command, push strobe, bit op, bank base and pointer word
  localparam logic [7:0]  IDX_ALU_CMD    = 8'hA0;
  localparam logic [7:0]  IDX_PUSH       = 8'hA1;
  localparam logic [7:0]  IDX_BIT_OP     = 8'hA2;
  localparam logic [7:0]  IDX_BANK_BASE  = 8'hA3;
  localparam logic [7:0]  IDX_PTR_WORD   = 8'hA4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_STACK_TOP  = 8'h07;
  localparam logic [7:0]  RST_ZERO       = 8'h00;

  // ----------------------------------------------------------------
  // Status word field positions
  // ----------------------------------------------------------------
  localparam int          POS_CARRY      = 7;
  localparam int          POS_NIBBLE     = 6;
  localparam int          POS_USER0      = 5;
  localparam int          POS_BANK_HI    = 4;
  localparam int          POS_BANK_LO    = 3;
  localparam int          POS_SIGN_WRAP  = 2;
  localparam int          POS_USER1      = 1;
  localparam int          POS_ODD_ONES   = 0;
  localparam logic [7:0]  STATUS_SW_MASK = 8'hFE;
  localparam logic [7:0]  MUL_LIMIT      = 8'hFF;

  // Bit operation fields in the bit-op register
  localparam int          BITOP_SEL_LO   = 0;
  localparam int          BITOP_VAL      = 3;
  localparam int          BITOP_TGT_LO   = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ALU_NONE, ALU_ADD, ALU_ADDC, ALU_SUBB, ALU_MUL, ALU_DIV
  } alu_op_t;

  typedef enum logic [2:0] {
    TGT_STACK, TGT_PTR_LOW, TGT_PTR_HIGH, TGT_STATUS, TGT_MAIN, TGT_AUX
  } bit_tgt_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [9:0]  address;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef enum {
    BUS_IDLE, BUS_DONE
  } bus_state_t;

endpackage : core_sfr_pkg

// ### verif/core_sfr_assertions.sv
/*
  Checker for the core special-register set.
  Bound to every core_sfr instance; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module core_sfr_assertions
  import core_sfr_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Core views
  input wire logic [15:0] indirect_pointer,
  input wire logic [4:0]  bank_base_addr
);
  logic       take;
  logic [7:0] idx;
  assign take = (avs_read | avs_write) & avs_waitrequest;
  assign idx  = avs_address[9:2];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_ANSWER: assert property (take |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  AST_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  AST_RST: assert property ($rose(rst_n) |-> avs_waitrequest
    && indirect_pointer == 16'h0000 && bank_base_addr == 5'h00
    && avs_readdata == 32'h0)
    else $error("outputs wrong after reset");
  AST_PLO: assert property (take && avs_write && idx == IDX_PTR_LOW
    |-> ##2 indirect_pointer[7:0] == $past(avs_writedata[7:0], 2))
    else $error("pointer low byte not written");
  AST_PHI: assert property (take && avs_write && idx == IDX_PTR_HIGH
    |-> ##2 indirect_pointer[15:8] == $past(avs_writedata[7:0], 2))
    else $error("pointer high byte not written");
  AST_BANK: assert property (take && avs_write && idx == IDX_STATUS
    |-> ##2 bank_base_addr == {$past(avs_writedata[4:3], 2), 3'b000})
    else $error("bank base does not follow select");
  AST_UNMAP: assert property (take && avs_read && idx < 8'h81
    |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_HOLD: assert property (!(take && avs_read)
    |=> $stable(avs_readdata))
    else $error("read data changed without read");

  cover property (take && avs_write && idx == IDX_ALU_CMD);
  cover property (take && avs_write && idx == IDX_PUSH);
  cover property (take && avs_read && idx == IDX_STATUS);
endmodule : core_sfr_assertions

bind core_sfr core_sfr_assertions chk_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .indirect_pointer(indirect_pointer), .bank_base_addr(bank_base_addr)
);
`default_nettype wire

// ### verif/core_sfr_tb.sv
/*
  Self-checking bench for core_sfr over its Avalon-MM port.
  Assumes the package indices and the one-cycle bus answer.
*/
`timescale 1ns/1ps
`default_nettype none
module core_sfr_tb
  import core_sfr_pkg::*;
;
  logic        sys_clk         = 1'b0;
  logic        rst_n           = 1'b0;
  logic [9:0]  avs_address     = 10'h000;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] indirect_pointer;
  logic [4:0]  bank_base_addr;
  int          failures        = 0;
  int          n_compared      = 0;
  int          cycles          = 0;

  always #5 sys_clk = ~sys_clk;

  core_sfr uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .indirect_pointer(indirect_pointer), .bank_base_addr(bank_base_addr)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic req(input logic rd, input logic [7:0] i,
                     input logic [7:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address   <= {i, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_read      <= rd;
    avs_write     <= ~rd;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : req

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    req(1'b0, i, d, q);
  endtask : wr

  task automatic rc(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] q;
    req(1'b1, i, 8'h00, q);
    chk(q, e);
  endtask : rc

  task automatic alu(input alu_op_t op, input logic [7:0] a, b, st, m, x);
    wr(IDX_MAIN_OP, a);
    wr(IDX_AUX_OP, b);
    wr(IDX_ALU_CMD, {5'h00, op});
    rc(IDX_STATUS, {24'h0, st});
    rc(IDX_MAIN_OP, {24'h0, m});
    rc(IDX_AUX_OP, {24'h0, x});
  endtask : alu

  task automatic reset_dut;
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : reset_dut

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_dut();
    rc(IDX_STACK_TOP, 32'h07);
    rc(IDX_PTR_LOW, 32'h00);
    rc(IDX_PTR_HIGH, 32'h00);
    rc(IDX_STATUS, 32'h00);
    rc(IDX_MAIN_OP, 32'h00);
    rc(IDX_AUX_OP, 32'h00);
    wr(IDX_PTR_LOW, 8'h34);
    wr(IDX_PTR_HIGH, 8'hC2);
    @(posedge sys_clk);
    chk({16'h0, indirect_pointer}, 32'hC234);
    rc(IDX_PTR_WORD, 32'hC234);
    for (int b = 0; b < 4; b++) begin
      wr(IDX_STATUS, 8'(b << 3));
      @(posedge sys_clk);
      chk({27'h0, bank_base_addr}, 32'(b * 8));
      rc(IDX_STATUS, 32'(b << 3));
      rc(IDX_BANK_BASE, 32'(b * 8));
    end
    wr(IDX_STATUS, 8'h22);
    alu(ALU_MUL, 8'h10, 8'h10, 8'h26, 8'h00, 8'h01);
    alu(ALU_DIV, 8'h07, 8'h02, 8'h22, 8'h03, 8'h01);
    alu(ALU_DIV, 8'h03, 8'h00, 8'h26, 8'h03, 8'h00);
    alu(ALU_ADD, 8'h88, 8'h88, 8'hE7, 8'h10, 8'h88);
    alu(ALU_SUBB, 8'h10, 8'h01, 8'h63, 8'h0E, 8'h01);
    alu(ALU_ADDC, 8'h0E, 8'h01, 8'h22, 8'h0F, 8'h01);
    alu(ALU_ADD, 8'h08, 8'h08, 8'h63, 8'h10, 8'h08);
    alu(ALU_MUL, 8'h03, 8'h05, 8'h22, 8'h0F, 8'h00);
    wr(IDX_STATUS, 8'h01);
    rc(IDX_STATUS, 32'h00);
    wr(IDX_MAIN_OP, 8'h00);
    wr(IDX_BIT_OP, 8'h4F);
    rc(IDX_MAIN_OP, 32'h80);
    rc(IDX_STATUS, 32'h01);
    wr(IDX_BIT_OP, 8'h3D);
    rc(IDX_STATUS, 32'h21);
    wr(IDX_STACK_TOP, 8'hFF);
    rc(IDX_STACK_TOP, 32'hFF);
    wr(IDX_PUSH, 8'h5A);
    rc(IDX_STACK_TOP, 32'h00);
    wr(IDX_PUSH, 8'hA5);
    rc(IDX_STACK_TOP, 32'h01);
    rc(IDX_PUSH, 32'hA5);
    wr(8'h10, 8'hFF);
    rc(8'h10, 32'h00);
    reset_dut();
    rc(IDX_STACK_TOP, 32'h07);
    chk({16'h0, indirect_pointer}, 32'h0);
    finish_test();
  end
endmodule : core_sfr_tb
`default_nettype wire
